// >>> inc/mgd_pkg.sv
`default_nettype none
package mgd_pkg;
    // Register offsets (byte addresses on the plain register port)
    localparam logic [7:0] MGD_CTRL_OFS = 8'h00;
    localparam logic [7:0] MGD_FSIZE_OFS = 8'h04;
    localparam logic [7:0] MGD_STATUS_OFS = 8'h08;
    localparam logic [7:0] MGD_LASTOP_OFS = 8'h0C;
    localparam logic [7:0] MGD_INFO_OFS = 8'h10;
    // Field positions
    localparam int MGD_CTRL_EN_BIT = 0;
    localparam int MGD_FS0_LSB = 0;
    localparam int MGD_FS1_LSB = 8;
    localparam int MGD_ST_OP_LSB = 8;
    localparam int MGD_ST_ILL_BIT = 16;
    localparam int MGD_INFO_CYC_LSB = 8;
    localparam int MGD_INFO_VAR_BIT = 16;
    // Flag bit positions and flag masks inside the four-bit status group
    localparam int MGD_FLAG_N = 3;
    localparam int MGD_FLAG_C = 2;
    localparam int MGD_FLAG_Z = 1;
    localparam int MGD_FLAG_V = 0;
    localparam logic [3:0] MGD_F_NONE = 4'h0;
    localparam logic [3:0] MGD_F_NZ = 4'hA;
    localparam logic [3:0] MGD_F_Z = 4'h2;
    localparam logic [3:0] MGD_F_CZ = 4'h6;
    localparam logic [3:0] MGD_F_NCZV = 4'hF;
    localparam logic [3:0] MGD_F_V = 4'h1;
    // Reset values
    localparam logic MGD_CTRL_EN_RST = 1'h1;
    localparam logic [5:0] MGD_FS0_RST = 6'h20;
    localparam logic [5:0] MGD_FS1_RST = 6'h20;
    localparam logic [3:0] MGD_FLAGS_RST = 4'h0;
    // Timing counts in core cycles, and the byte move size in bits
    localparam logic [7:0] MGD_MEM_ACC_CYC = 8'h02;
    localparam logic [7:0] MGD_MULTI_REGISTER_STORE_BASE_CYC = 8'h02;
    localparam logic [7:0] MGD_MULTI_REGISTER_STORE_REG_CYC = 8'h02;
    localparam logic [5:0] MGD_BYTE_SIZE = 6'h08;

    // Decoded instruction class
    typedef enum logic [4:0] {
        OP_NONE = 5'h00,
        OP_BYTE_ST_IND = 5'h01,
        OP_BYTE_CPY_IND = 5'h02,
        OP_BYTE_LD_DISP = 5'h03,
        OP_BYTE_ST_ABS = 5'h04,
        OP_BYTE_CPY_ABS = 5'h05,
        OP_REG_MOVE = 5'h06,
        OP_FLD_LD_IND = 5'h07,
        OP_FLD_CPY_IND = 5'h08,
        OP_FLD_LD_ABS = 5'h09,
        OP_FLD_ST_ABS = 5'h0A,
        OP_FLD_CPY_ABS = 5'h0B,
        OP_ADD_IMM = 5'h0C,
        OP_CMP_IMM = 5'h0D,
        OP_BIT_TEST = 5'h0E,
        OP_MULTI_STORE = 5'h0F,
        OP_ROTATE_LEFT = 5'h10,
        OP_NEG_BORROW = 5'h11,
        OP_AND_COMPL = 5'h12,
        OP_OR_IMM = 5'h13,
        OP_LOAD_IMM = 5'h14
    } mgd_op_t;

    // Pointer adjustment of a field or byte access
    typedef enum logic [1:0] {
        PTR_PLAIN = 2'h0,
        PTR_PREDEC = 2'h1,
        PTR_POSTINC = 2'h2
    } mgd_ptr_t;

    // Decode result handed to the execution side
    typedef struct packed {
        logic valid;
        mgd_op_t op;
        logic [2:0] words;
        logic [7:0] cycles;
        logic var_time;
        logic [3:0] flag_upd;
        logic [3:0] flag_clr;
        logic [3:0] src_reg;
        logic [3:0] dst_reg;
        logic rfile;
        logic cross_file;
        logic fsel;
        mgd_ptr_t ptr_mode;
        logic [4:0] konst;
        logic illegal;
    } mgd_dec_t;
endpackage
`default_nettype wire

// >>> hdl/mgd_decoder.sv
`default_nettype none
// Operation
// - Upper pattern 1000 110S decodes as byte store register to register-addressed memory.
// - Upper pattern 1001 110S is byte copy between pointers, flags untouched.
// - 1010 111S is two-word byte load with displacement; N,Z set, V cleared.
// - 0000 0101 111R SSSS is three-word byte store to absolute address.
// - 0000 0011 0100 0000 is five-word byte copy absolute to absolute.
// - 0100 11MS copies register to register; N,Z set, V cleared.
// - 1000 01FS loads a field via pointer; N,Z set, V cleared.
// - 1010 01FS pre-decrements the pointer then loads; N,Z set, V cleared.
// - 1001 01FS loads then post-increments the pointer; N,Z set, V cleared.
// - Field copies: 1000 10FS plain, 1010 10FS pre-dec, 1001 10FS post-inc; no flags.
// - 0000 01F1 101R loads field from absolute, N,Z; 100R stores to absolute.
// - 0000 01F1 1100 0000 is five-word absolute to absolute field copy.
// - Field move time follows selected field size and operand bit alignment.
// - Add immediate: 16-bit two words two cycles, 32-bit three and three; NCZV.
// - Compare immediate: 010R two words, 011R three words; sets NCZV.
// - 0001 11KK bit test with five-bit constant, one cycle, Z only.
// - 0000 1001 100R is two-word multi register store; time follows list and alignment.
// - 0110 100S rotate left by register, one cycle, C and Z only.
// - 0000 0011 110R negate with borrow, one cycle, NCZV.
// - 0101 001S and with complement, one word, Z only.
// - Or immediate 101R, three words three cycles, Z only.
// - Load immediate 110R two words, 111R 32-bit; N,Z set, V cleared.
// - M bit lets a register move cross between the A and B halves.
// - R bit selects register file half, F bit selects field size setting.
module mgd_decoder
    import mgd_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // Register port
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    // Instruction fetch side
    input wire logic [15:0] opcode_i,
    input wire logic op_valid_i,
    input wire logic [15:0] list_i,
    input wire logic [4:0] align_i,
    // Execution side
    input wire logic exec_done_i,
    input wire logic [3:0] res_flags_i,
    output mgd_dec_t dec_o,
    output logic [3:0] flags_o
);

    // Offsets reach 0x10, so fewer than five address bits would alias registers
    if (ADDR_W < 5) begin : g_addr_w_check
        $error("mgd_decoder: ADDR_W too small for the register map");
    end

    logic ctrl_en_r;
    logic [5:0] fs0_r;
    logic [5:0] fs1_r;
    logic [3:0] flags_r;
    logic [15:0] lastop_r;
    logic [31:0] rdata_r;
    mgd_dec_t dec_r;
    mgd_dec_t dec_nxt;
    logic take;
    logic [5:0] fsize;
    logic [6:0] span;
    logic [7:0] accesses;
    logic [7:0] fld_cyc;
    logic [4:0] list_cnt;
    logic [7:0] multi_register_store_cyc;
    logic [7:0] reg_addr;

    // Decoding is gated by software so a halted core sees no fresh results
    assign take = op_valid_i && ctrl_en_r;
    assign reg_addr = 8'(addr_i);

    // Field size from the setting the F bit picks; zero stands for 32 bits
    always_comb begin
        fsize = opcode_i[9] ? fs1_r : fs0_r;
        if (fsize == 6'h00) begin
            fsize = 6'h20;
        end
        // Byte forms sit inside the pointer and absolute groups, so they are carved out
        // by their own bits; otherwise a byte move would be timed as a full field
        if (!((opcode_i[15:14] == 2'h2 && opcode_i[11:10] != 2'h3) ||
              (opcode_i[15:10] == 6'h01 && opcode_i[8] && opcode_i[7:5] != 3'h7))) begin
            fsize = MGD_BYTE_SIZE;
        end
    end

    // Memory accesses grow with size and the starting bit inside a word
    always_comb begin
        span = 7'(align_i[3:0]) + 7'(fsize) + 7'h0F;
        accesses = 8'(span[6:4]);
        fld_cyc = 8'h01 + 8'(accesses * MGD_MEM_ACC_CYC);
    end

    // Multi store timing: per register, plus a penalty when the stack is misaligned
    always_comb begin
        list_cnt = 5'h00;
        for (int i = 0; i < 16; i++) begin
            list_cnt = list_cnt + 5'(list_i[i]);
        end
        multi_register_store_cyc = MGD_MULTI_REGISTER_STORE_BASE_CYC + 8'(list_cnt * MGD_MULTI_REGISTER_STORE_REG_CYC);
        if (align_i != 5'h00) begin
            multi_register_store_cyc = multi_register_store_cyc + 8'(list_cnt);
        end
    end

    // Opcode decode
    always_comb begin
        dec_nxt = '0;
        dec_nxt.valid = 1'b1;
        dec_nxt.op = OP_NONE;
        dec_nxt.words = 3'h1;
        dec_nxt.cycles = 8'h01;
        dec_nxt.src_reg = opcode_i[8:5];
        dec_nxt.dst_reg = opcode_i[3:0];
        dec_nxt.rfile = opcode_i[4];
        dec_nxt.fsel = opcode_i[9];
        dec_nxt.ptr_mode = PTR_PLAIN;
        dec_nxt.konst = opcode_i[9:5];
        if (opcode_i[15:9] == 7'h46) begin
            dec_nxt.op = OP_BYTE_ST_IND;
        end else if (opcode_i[15:9] == 7'h4E) begin
            dec_nxt.op = OP_BYTE_CPY_IND;
        end else if (opcode_i[15:9] == 7'h57) begin
            dec_nxt.op = OP_BYTE_LD_DISP;
            dec_nxt.words = 3'h2;
            dec_nxt.cycles = fld_cyc;
            dec_nxt.var_time = 1'b1;
            dec_nxt.flag_upd = MGD_F_NZ | MGD_F_V;
            dec_nxt.flag_clr = MGD_F_V;
        end else if (opcode_i[15:5] == 11'h02F) begin
            dec_nxt.op = OP_BYTE_ST_ABS;
            dec_nxt.words = 3'h3;
            dec_nxt.cycles = fld_cyc;
            dec_nxt.var_time = 1'b1;
            dec_nxt.src_reg = opcode_i[3:0];
        end else if (opcode_i == 16'h0340) begin
            dec_nxt.op = OP_BYTE_CPY_ABS;
            dec_nxt.words = 3'h5;
        end else if (opcode_i[15:10] == 6'h13) begin
            dec_nxt.op = OP_REG_MOVE;
            dec_nxt.cross_file = opcode_i[9];
            dec_nxt.src_reg = {opcode_i[8:5]};
            dec_nxt.flag_upd = MGD_F_NZ | MGD_F_V;
            dec_nxt.flag_clr = MGD_F_V;
        end else if (opcode_i[15:14] == 2'h2 && opcode_i[11:10] != 2'h0 &&
                     opcode_i[13:12] != 2'h3) begin
            // Pointer field moves: bits 13:12 pick plain, post-inc or pre-dec
            dec_nxt.cycles = fld_cyc;
            dec_nxt.var_time = 1'b1;
            dec_nxt.ptr_mode = (opcode_i[13:12] == 2'h2) ? PTR_PREDEC :
                               (opcode_i[13:12] == 2'h1) ? PTR_POSTINC : PTR_PLAIN;
            if (opcode_i[11:10] == 2'h1) begin
                dec_nxt.op = OP_FLD_LD_IND;
                dec_nxt.flag_upd = MGD_F_NZ | MGD_F_V;
                dec_nxt.flag_clr = MGD_F_V;
            end else if (opcode_i[11:10] == 2'h2) begin
                dec_nxt.op = OP_FLD_CPY_IND;
            end else begin
                // Unlisted byte forms here report the fixed illegal timing
                dec_nxt.illegal = 1'b1;
                dec_nxt.cycles = 8'h01;
                dec_nxt.var_time = 1'b0;
            end
        end else if (opcode_i[15:10] == 6'h01 && opcode_i[8]) begin
            dec_nxt.words = 3'h3;
            dec_nxt.cycles = fld_cyc;
            dec_nxt.var_time = 1'b1;
            if (opcode_i[7:5] == 3'h5) begin
                dec_nxt.op = OP_FLD_LD_ABS;
                dec_nxt.flag_upd = MGD_F_NZ | MGD_F_V;
                dec_nxt.flag_clr = MGD_F_V;
            end else if (opcode_i[7:5] == 3'h4) begin
                dec_nxt.op = OP_FLD_ST_ABS;
                dec_nxt.src_reg = opcode_i[3:0];
            end else if (opcode_i[7:0] == 8'hC0) begin
                dec_nxt.op = OP_FLD_CPY_ABS;
                dec_nxt.words = 3'h5;
            end else begin
                dec_nxt.illegal = 1'b1;
                dec_nxt.words = 3'h1;
                dec_nxt.cycles = 8'h01;
                dec_nxt.var_time = 1'b0;
            end
        end else if (opcode_i[15:8] == 8'h0B && opcode_i[7:5] != 3'h4 &&
                     opcode_i[7:5] != 3'h6 && opcode_i[7:5] != 3'h7) begin
            // Immediate forms: bit 5 clear means 16-bit, set means 32-bit
            dec_nxt.words = opcode_i[5] ? 3'h3 : 3'h2;
            dec_nxt.cycles = opcode_i[5] ? 8'h03 : 8'h02;
            dec_nxt.flag_upd = MGD_F_NCZV;
            if (opcode_i[7:6] == 2'h0) begin
                dec_nxt.op = OP_ADD_IMM;
            end else if (opcode_i[7:6] == 2'h1) begin
                dec_nxt.op = OP_CMP_IMM;
            end else begin
                dec_nxt.op = OP_OR_IMM;
                dec_nxt.flag_upd = MGD_F_Z;
            end
        end else if (opcode_i[15:6] == 10'h027) begin
            dec_nxt.op = OP_LOAD_IMM;
            dec_nxt.words = opcode_i[5] ? 3'h3 : 3'h2;
            dec_nxt.cycles = opcode_i[5] ? 8'h03 : 8'h02;
            dec_nxt.flag_upd = MGD_F_NZ | MGD_F_V;
            dec_nxt.flag_clr = MGD_F_V;
        end else if (opcode_i[15:10] == 6'h07) begin
            dec_nxt.op = OP_BIT_TEST;
            dec_nxt.flag_upd = MGD_F_Z;
        end else if (opcode_i[15:5] == 11'h04C) begin
            dec_nxt.op = OP_MULTI_STORE;
            dec_nxt.words = 3'h2;
            dec_nxt.cycles = multi_register_store_cyc;
            dec_nxt.var_time = 1'b1;
        end else if (opcode_i[15:9] == 7'h34) begin
            dec_nxt.op = OP_ROTATE_LEFT;
            dec_nxt.flag_upd = MGD_F_CZ;
        end else if (opcode_i[15:5] == 11'h01E) begin
            dec_nxt.op = OP_NEG_BORROW;
            dec_nxt.flag_upd = MGD_F_NCZV;
        end else if (opcode_i[15:9] == 7'h29) begin
            dec_nxt.op = OP_AND_COMPL;
            dec_nxt.flag_upd = MGD_F_Z;
        end else begin
            dec_nxt.illegal = 1'b1;
        end
    end

    // Decode result register; valid is a one-cycle pulse, the rest is held
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            dec_r <= '0;
        end else if (take) begin
            dec_r <= dec_nxt;
        end else begin
            dec_r.valid <= 1'b0;
        end
    end

    // Last opcode taken, for software inspection
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            lastop_r <= 16'h0000;
        end else if (take) begin
            lastop_r <= opcode_i;
        end
    end

    // Status flags: only the affected ones move, cleared ones go to zero
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            flags_r <= MGD_FLAGS_RST;
        end else if (exec_done_i) begin
            flags_r <= (flags_r & ~dec_r.flag_upd) |
                       (res_flags_i & dec_r.flag_upd & ~dec_r.flag_clr);
        end
    end

    // Control and field size settings written by software
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            ctrl_en_r <= MGD_CTRL_EN_RST;
            fs0_r <= MGD_FS0_RST;
            fs1_r <= MGD_FS1_RST;
        end else if (wr_i) begin
            if (reg_addr == MGD_CTRL_OFS) begin
                ctrl_en_r <= wdata_i[MGD_CTRL_EN_BIT];
            end
            if (reg_addr == MGD_FSIZE_OFS) begin
                fs0_r <= wdata_i[MGD_FS0_LSB +: 6];
                fs1_r <= wdata_i[MGD_FS1_LSB +: 6];
            end
        end
    end

    // Read data stands only in the cycle after the strobe; unmapped reads give zero
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            rdata_r <= 32'h0000_0000;
        end else begin
            rdata_r <= 32'h0000_0000;
            if (rd_i) begin
                unique case (reg_addr)
                    MGD_CTRL_OFS: rdata_r[MGD_CTRL_EN_BIT] <= ctrl_en_r;
                    MGD_FSIZE_OFS: begin
                        rdata_r[MGD_FS0_LSB +: 6] <= fs0_r;
                        rdata_r[MGD_FS1_LSB +: 6] <= fs1_r;
                    end
                    MGD_STATUS_OFS: begin
                        rdata_r[3:0] <= flags_r;
                        rdata_r[MGD_ST_OP_LSB +: 5] <= dec_r.op;
                        rdata_r[MGD_ST_ILL_BIT] <= dec_r.illegal;
                    end
                    MGD_LASTOP_OFS: rdata_r[15:0] <= lastop_r;
                    MGD_INFO_OFS: begin
                        rdata_r[2:0] <= dec_r.words;
                        rdata_r[MGD_INFO_CYC_LSB +: 8] <= dec_r.cycles;
                        rdata_r[MGD_INFO_VAR_BIT] <= dec_r.var_time;
                    end
                    default: rdata_r <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign rdata_o = rdata_r;
    assign dec_o = dec_r;
    assign flags_o = flags_r;

    // Checks on the decode results
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    a_byte_store_dec: assert property (take && opcode_i[15:9] == 7'h46 |=>
        dec_o.valid && dec_o.op == OP_BYTE_ST_IND && dec_o.words == 3'h1)
        else $error("byte store decode wrong");
    a_byte_copy_flags: assert property (take && opcode_i[15:9] == 7'h4E |=>
        dec_o.op == OP_BYTE_CPY_IND && dec_o.flag_upd == 4'h0)
        else $error("byte copy must leave flags");
    a_byte_disp_len: assert property (take && opcode_i[15:9] == 7'h57 |=>
        dec_o.words == 3'h2 && dec_o.flag_clr == 4'h1 && dec_o.flag_upd == 4'hB)
        else $error("byte displacement load wrong");
    a_byte_abs_len: assert property (take && opcode_i[15:5] == 11'h02F |=>
        dec_o.words == 3'h3 && dec_o.src_reg == $past(opcode_i[3:0]))
        else $error("byte absolute store wrong");
    a_byte_abs_copy: assert property (take && opcode_i == 16'h0340 |=>
        dec_o.words == 3'h5 && dec_o.op == OP_BYTE_CPY_ABS)
        else $error("byte absolute copy wrong");
    a_reg_move_dec: assert property (take && opcode_i[15:10] == 6'h13 |=>
        dec_o.flag_upd == 4'hB && dec_o.cross_file == $past(opcode_i[9]))
        else $error("register move decode wrong");
    a_fld_ptr_mode: assert property (take && opcode_i[15:10] == 6'h29 |=>
        dec_o.op == OP_FLD_LD_IND && dec_o.ptr_mode == PTR_PREDEC)
        else $error("pre-decrement load wrong");
    a_fld_post_inc: assert property (take && opcode_i[15:10] == 6'h26 |=>
        dec_o.op == OP_FLD_CPY_IND && dec_o.ptr_mode == PTR_POSTINC && dec_o.flag_upd == 4'h0)
        else $error("post-increment copy wrong");
    a_fld_abs_load: assert property (take && opcode_i[15:10] == 6'h01 && opcode_i[8:5] == 4'hD
        |=> dec_o.op == OP_FLD_LD_ABS && dec_o.words == 3'h3)
        else $error("absolute field load wrong");
    a_fld_time_size: assert property (take && opcode_i[15:10] == 6'h21 && fsize == 6'h20 &&
        align_i[3:0] == 4'h8 |=> dec_o.cycles == 8'h07)
        else $error("field time ignores size or alignment");
    a_imm_length: assert property (take && opcode_i[15:5] == 11'h059 |=>
        dec_o.words == 3'h3 && dec_o.cycles == 8'h03 && dec_o.flag_upd == 4'hF)
        else $error("add immediate 32-bit wrong");
    a_cmp_short: assert property (take && opcode_i[15:5] == 11'h05A |=>
        dec_o.op == OP_CMP_IMM && dec_o.words == 3'h2)
        else $error("compare immediate wrong");
    a_multi_register_store_time: assert property (take && opcode_i[15:5] == 11'h04C && list_i == 16'h0007 &&
        align_i == 5'h00 |=> dec_o.cycles == 8'h08)
        else $error("multi store timing wrong");
    a_rotate_flags: assert property (take && opcode_i[15:9] == 7'h34 |=>
        dec_o.flag_upd == 4'h6 && dec_o.cycles == 8'h01)
        else $error("rotate flags wrong");
    a_or_imm_flags: assert property (take && opcode_i[15:5] == 11'h05D |=>
        dec_o.flag_upd == 4'h2 && dec_o.words == 3'h3)
        else $error("or immediate wrong");
    a_flag_keep: assert property (exec_done_i |=>
        ((flags_o ^ $past(flags_r)) & ~$past(dec_r.flag_upd)) == 4'h0)
        else $error("unaffected flag changed");
    a_read_one_cycle: assert property (!rd_i |=> rdata_o == 32'h0000_0000)
        else $error("read data outside its cycle");

    c_field_load: cover property (take && opcode_i[15:10] == 6'h21 ##1 exec_done_i);
    c_multi_store: cover property (take && opcode_i[15:5] == 11'h04C && list_i != 16'h0000);
    c_illegal_op: cover property (dec_o.valid && dec_o.illegal);
    c_status_read: cover property (rd_i && reg_addr == MGD_STATUS_OFS);

endmodule
`default_nettype wire

// >>> bench/move_and_general_instruction_decode_bench.sv
`default_nettype none
module move_and_general_instruction_decode_bench
    import mgd_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    // Stimulus side, all driven by the bench
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h00000000;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [15:0] opcode_i = 16'h0000;
    logic op_valid_i = 1'b0;
    logic [15:0] list_i = 16'h0000;
    logic [4:0] align_i = 5'h00;
    logic exec_done_i = 1'b0;
    logic [3:0] res_flags_i = 4'h0;
    // Observed side
    logic [31:0] rdata_o;
    mgd_dec_t dec_o;
    logic [3:0] flags_o;
    int fail_count = 0;
    int cmp_count = 0;

    // 200 MHz core clock
    always #2.5 clock_i = ~clock_i;

    mgd_decoder #(.ADDR_W(8)) mgd_decoder_inst (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .opcode_i(opcode_i),
        .op_valid_i(op_valid_i), .list_i(list_i), .align_i(align_i),
        .exec_done_i(exec_done_i), .res_flags_i(res_flags_i), .dec_o(dec_o), .flags_o(flags_o)
    );

    // Case equality so an unknown never counts as a match
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // One-cycle write strobe; the slave never stalls
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clock_i);
        wr_i <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic reg_rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clock_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clock_i);
        rd_i <= 1'b0;
        #1;
        chk(rdata_o, e);
    endtask

    // Leaves time in the cycle where the decode result is valid
    task automatic decode(input logic [15:0] op);
        @(posedge clock_i);
        opcode_i <= op;
        op_valid_i <= 1'b1;
        @(posedge clock_i);
        op_valid_i <= 1'b0;
        #1;
    endtask

    task automatic retire(input logic [3:0] res);
        @(posedge clock_i);
        exec_done_i <= 1'b1;
        res_flags_i <= res;
        @(posedge clock_i);
        exec_done_i <= 1'b0;
        #1;
    endtask

    // Cycle value FF means the count is operand dependent; flags run from all set and all clear
    task automatic chk_op(input logic [15:0] op, input mgd_op_t cls, input logic [2:0] wd,
                          input logic [7:0] cyc, input logic [3:0] aff, input logic [3:0] clr);
        logic [3:0] old;
        for (int k = 0; k < 2; k++) begin
            old = (k == 0) ? 4'hF : 4'h0;
            decode(16'h0B05);
            retire(old);
            decode(op);
            chk({31'h0, dec_o.valid}, 32'h1);
            chk({27'h0, dec_o.op}, {27'h0, cls});
            chk({29'h0, dec_o.words}, {29'h0, wd});
            if (cyc == 8'hFF) begin
                chk({31'h0, dec_o.var_time}, 32'h1);
            end else begin
                chk({24'h0, dec_o.cycles}, {24'h0, cyc});
            end
            retire(~old);
            chk({28'h0, flags_o}, {28'h0, (old & ~(aff | clr)) | (~old & aff)});
        end
    endtask

    // A hung run still reaches the verdict
    initial begin
        repeat (20000) @(posedge clock_i);
        fail_count++;
        test_done();
    end

    initial begin
        repeat (8) @(posedge clock_i);
        rst_n_i <= 1'b1;
        reg_rd(MGD_CTRL_OFS, 32'h00000001);
        reg_rd(MGD_FSIZE_OFS, 32'h00002020);
        reg_rd(MGD_STATUS_OFS, 32'h00000000);
        reg_wr(8'h14, 32'hFFFFFFFF);
        reg_rd(8'h14, 32'h00000000);
        $display("test reset_and_map done");
        chk_op(16'h8C12, OP_BYTE_ST_IND, 3'h1, 8'h01, 4'h0, 4'h0);
        chk_op(16'h9C34, OP_BYTE_CPY_IND, 3'h1, 8'h01, 4'h0, 4'h0);
        chk_op(16'hAE56, OP_BYTE_LD_DISP, 3'h2, 8'hFF, 4'hA, 4'h1);
        chk_op(16'h05E7, OP_BYTE_ST_ABS, 3'h3, 8'hFF, 4'h0, 4'h0);
        chk_op(16'h0340, OP_BYTE_CPY_ABS, 3'h5, 8'h01, 4'h0, 4'h0);
        chk_op(16'h4E21, OP_REG_MOVE, 3'h1, 8'h01, 4'hA, 4'h1);
        chk_op(16'h8412, OP_FLD_LD_IND, 3'h1, 8'hFF, 4'hA, 4'h1);
        chk_op(16'hA612, OP_FLD_LD_IND, 3'h1, 8'hFF, 4'hA, 4'h1);
        chk_op(16'h9412, OP_FLD_LD_IND, 3'h1, 8'hFF, 4'hA, 4'h1);
        chk_op(16'h8812, OP_FLD_CPY_IND, 3'h1, 8'hFF, 4'h0, 4'h0);
        chk_op(16'hA812, OP_FLD_CPY_IND, 3'h1, 8'hFF, 4'h0, 4'h0);
        chk_op(16'h9A12, OP_FLD_CPY_IND, 3'h1, 8'hFF, 4'h0, 4'h0);
        chk_op(16'h07A3, OP_FLD_LD_ABS, 3'h3, 8'hFF, 4'hA, 4'h1);
        chk_op(16'h0583, OP_FLD_ST_ABS, 3'h3, 8'hFF, 4'h0, 4'h0);
        chk_op(16'h07C0, OP_FLD_CPY_ABS, 3'h5, 8'hFF, 4'h0, 4'h0);
        chk_op(16'h0B05, OP_ADD_IMM, 3'h2, 8'h02, 4'hF, 4'h0);
        chk_op(16'h0B25, OP_ADD_IMM, 3'h3, 8'h03, 4'hF, 4'h0);
        chk_op(16'h0B45, OP_CMP_IMM, 3'h2, 8'h02, 4'hF, 4'h0);
        chk_op(16'h0B65, OP_CMP_IMM, 3'h3, 8'h03, 4'hF, 4'h0);
        chk_op(16'h1C05, OP_BIT_TEST, 3'h1, 8'h01, 4'h2, 4'h0);
        chk_op(16'h0993, OP_MULTI_STORE, 3'h2, 8'hFF, 4'h0, 4'h0);
        chk_op(16'h6825, OP_ROTATE_LEFT, 3'h1, 8'h01, 4'h6, 4'h0);
        chk_op(16'h03C5, OP_NEG_BORROW, 3'h1, 8'h01, 4'hF, 4'h0);
        chk_op(16'h5225, OP_AND_COMPL, 3'h1, 8'h01, 4'h2, 4'h0);
        chk_op(16'h0BA5, OP_OR_IMM, 3'h3, 8'h03, 4'h2, 4'h0);
        chk_op(16'h09C5, OP_LOAD_IMM, 3'h2, 8'h02, 4'hA, 4'h1);
        chk_op(16'h09E5, OP_LOAD_IMM, 3'h3, 8'h03, 4'hA, 4'h1);
        $display("test decode_table done");
        decode(16'h4E21);
        chk({31'h0, dec_o.cross_file}, 32'h1);
        chk({24'h0, dec_o.src_reg, dec_o.dst_reg}, 32'h00000011);
        decode(16'h4C31);
        chk({31'h0, dec_o.cross_file}, 32'h0);
        chk({31'h0, dec_o.rfile}, 32'h1);
        decode(16'hA612);
        chk({30'h0, dec_o.ptr_mode}, {30'h0, PTR_PREDEC});
        chk({31'h0, dec_o.fsel}, 32'h1);
        decode(16'h9412);
        chk({30'h0, dec_o.ptr_mode}, {30'h0, PTR_POSTINC});
        decode(16'h1FE5);
        chk({27'h0, dec_o.konst}, 32'h0000001F);
        decode(16'hE000);
        chk({31'h0, dec_o.illegal}, 32'h1);
        decode(16'h0B25);
        retire(4'h9);
        reg_rd(MGD_LASTOP_OFS, 32'h00000B25);
        reg_rd(MGD_INFO_OFS, 32'h00000303);
        reg_rd(MGD_STATUS_OFS, 32'h00000C09);
        $display("test status_regs done");
        // Size0 stays 32, size1 becomes 1 so the F bit shows in the count
        reg_wr(MGD_FSIZE_OFS, 32'h00000120);
        decode(16'h8412);
        chk({24'h0, dec_o.cycles}, 32'h00000005);
        decode(16'h8612);
        chk({24'h0, dec_o.cycles}, 32'h00000003);
        align_i <= 5'h08;
        decode(16'h8412);
        chk({24'h0, dec_o.cycles}, 32'h00000007);
        align_i <= 5'h00;
        list_i <= 16'h0007;
        decode(16'h0993);
        chk({24'h0, dec_o.cycles}, 32'h00000008);
        align_i <= 5'h04;
        decode(16'h0993);
        chk({24'h0, dec_o.cycles}, 32'h0000000B);
        $display("test timing done");
        reg_wr(MGD_CTRL_OFS, 32'h00000000);
        decode(16'h8C12);
        chk({31'h0, dec_o.valid}, 32'h0);
        reg_wr(MGD_CTRL_OFS, 32'h00000001);
        decode(16'h8C12);
        chk({31'h0, dec_o.valid}, 32'h1);
        $display("test enable done");
        test_done();
    end
endmodule
`default_nettype wire
